// ---- design/dsd_params.svh ----
// constants for the data space address decoder
`ifndef DSD_PARAMS_SVH
`define DSD_PARAMS_SVH
`define DSD_MAP_TOP      16'h1100
`define DSD_REG_END      16'h0020
`define DSD_IO_END       16'h0060
`define DSD_XIO_END      16'h0100
`define DSD_IO_OFS       16'h0020
`define DSD_IO_BIT_END   6'h20
`define DSD_DISP_MAX     6'h3F
`define DSD_PTR_X        5'h1A
`define DSD_PTR_Y        5'h1C
`define DSD_PTR_Z        5'h1E
`define DSD_EE_RD_STALL  3'h4
`define DSD_EE_WR_STALL  3'h2
`define DSD_GPR0_ADR     6'h1E
`define DSD_GPR1_ADR     6'h2A
`define DSD_GPR2_ADR     6'h2B
`define DSD_SRAM_AW      12
`endif

// ---- design/dsd_pkg.sv ----
// types for the data space address decoder
package dsd_pkg;
   typedef enum logic [4:0] {
      DSD_RGN_REG  = 5'h01,
      DSD_RGN_IO   = 5'h02,
      DSD_RGN_XIO  = 5'h04,
      DSD_RGN_SRAM = 5'h08,
      DSD_RGN_NONE = 5'h10
   } dsd_rgn_t;
   typedef enum logic [3:0] {
      DSD_ST_IDLE  = 4'h1,
      DSD_ST_SRAM  = 4'h2,
      DSD_ST_STALL = 4'h4,
      DSD_ST_EEWR  = 4'h8
   } dsd_state_t;
   typedef enum logic [2:0] {
      DSD_AM_DIRECT = 3'h0,
      DSD_AM_DISP   = 3'h1,
      DSD_AM_PREDEC = 3'h2,
      DSD_AM_POSTINC= 3'h3,
      DSD_AM_IOPORT = 3'h4
   } dsd_amode_t;
endpackage

// ---- design/dsd_sram.sv ----
// internal data sram with registered read data
`timescale 1ns/1ps
`default_nettype none
module dsd_sram #(
   parameter int AW = 12
) (
   input  wire logic          mclk,
   input  wire logic          ce,
   input  wire logic          we,
   input  wire logic          re,
   input  wire logic [AW-1:0] addr,
   input  wire logic [7:0]    wdata,
   output logic      [7:0]    rdata
);
   logic [7:0] mem [0:(1<<AW)-1];

   // no reset on the array; read data registered
   always_ff @(posedge mclk) begin
      if (ce) begin
         if (we) begin
            mem[addr] <= wdata;
         end
         if (re) begin
            rdata <= mem[addr];
         end
      end
   end
endmodule
`default_nettype wire

// ---- design/dsd_decoder.sv ----
// data space address decoder with bit-io ops and eeprom stall control
`timescale 1ns/1ps
`default_nettype none
`include "dsd_params.svh"
module dsd_decoder import dsd_pkg::*; #(
   parameter int SRAM_AW = `DSD_SRAM_AW
) (
   input  wire logic        mclk,
   input  wire logic        arst_n,
   input  wire logic        ce,
   // cpu request
   input  wire logic        req,
   input  wire logic        we,
   input  wire dsd_amode_t  amode,
   input  wire logic [15:0] addr,
   input  wire logic [1:0]  ptr_sel,
   input  wire logic [5:0]  disp,
   input  wire logic [15:0] ptr_val,
   input  wire logic [7:0]  wdata,
   input  wire logic        bit_set,
   input  wire logic        bit_clr,
   input  wire logic        bit_test,
   input  wire logic [2:0]  bit_idx,
   // eeprom strobes from the control register
   input  wire logic        ee_rd_strobe,
   input  wire logic        ee_wr_strobe,
   input  wire logic        ee_wr_done,
   // peripheral side
   input  wire logic [7:0]  rf_rdata,
   input  wire logic [7:0]  io_rdata,
   input  wire logic [7:0]  io_w1c_mask,
   output logic             rf_we,
   output logic [4:0]       rf_addr,
   output logic             io_we,
   output logic             io_re,
   output logic [7:0]       io_addr,
   output logic [7:0]       io_wdata,
   output logic [7:0]       io_wmask,
   output logic             ptr_we,
   output logic [4:0]       ptr_reg,
   output logic [15:0]      ptr_next,
   // cpu answer
   output logic             ack,
   output logic             stall,
   output logic [7:0]       rdata,
   output logic             skip,
   output logic             bad_op,
   output logic             ee_busy,
   output logic [7:0]       gpr0,
   output logic [7:0]       gpr1,
   output logic [7:0]       gpr2
);
   //--------------------------------------------------
   // helpers
   //--------------------------------------------------
   // region of a data-space address
   function automatic dsd_rgn_t region(input logic [15:0] a);
      if (a < `DSD_REG_END) region = DSD_RGN_REG;
      else if (a < `DSD_IO_END) region = DSD_RGN_IO;
      else if (a < `DSD_XIO_END) region = DSD_RGN_XIO;
      else if (a < `DSD_MAP_TOP) region = DSD_RGN_SRAM;
      else region = DSD_RGN_NONE;
   endfunction

   // own general purpose register hit
   function automatic logic [1:0] gpr_hit(input logic [5:0] ioa);
      if (ioa == `DSD_GPR0_ADR) gpr_hit = 2'h1;
      else if (ioa == `DSD_GPR1_ADR) gpr_hit = 2'h2;
      else if (ioa == `DSD_GPR2_ADR) gpr_hit = 2'h3;
      else gpr_hit = 2'h0;
   endfunction

   //--------------------------------------------------
   // state
   //--------------------------------------------------
   typedef struct packed {
      dsd_state_t  st;
      logic [2:0]  cnt;
      logic        ee_busy;
      logic        ack;
      logic        skip;
      logic        bad;
      logic        sram_rd;
      logic [7:0]  rdata;
      logic [7:0]  gpr0;
      logic [7:0]  gpr1;
      logic [7:0]  gpr2;
   } dsd_regs_t;

   dsd_regs_t r;
   dsd_regs_t next_r;

   logic [15:0] eff;
   dsd_rgn_t    rgn;
   logic [5:0]  ioa;
   logic        bitop;
   logic        sram_we;
   logic        sram_re;
   logic [7:0]  sram_rdata;
   logic [7:0]  cur;
   logic [7:0]  bmask;
   logic [1:0]  gh;

   //--------------------------------------------------
   // address formation
   //--------------------------------------------------
   // port ops carry a 6-bit io address that maps to data space +0x20
   always_comb begin
      ptr_we   = 1'b0;
      ptr_next = ptr_val;
      case (ptr_sel)
         2'h0:    ptr_reg = `DSD_PTR_X;
         2'h1:    ptr_reg = `DSD_PTR_Y;
         default: ptr_reg = `DSD_PTR_Z;
      endcase
      case (amode)
         DSD_AM_DIRECT:  eff = addr;
         DSD_AM_DISP:    eff = ptr_val + {10'h000, disp};
         DSD_AM_PREDEC: begin
            eff      = ptr_val - 16'h0001;
            ptr_next = eff;
            ptr_we   = req && ce && r.st == DSD_ST_IDLE;
         end
         DSD_AM_POSTINC: begin
            eff      = ptr_val;
            ptr_next = ptr_val + 16'h0001;
            ptr_we   = req && ce && r.st == DSD_ST_IDLE;
         end
         DSD_AM_IOPORT:  eff = {10'h000, addr[5:0]} + `DSD_IO_OFS;
         default:        eff = addr;
      endcase
   end

   assign rgn   = region(eff);
   assign ioa   = 6'(eff[7:0] - `DSD_IO_OFS);
   assign gh    = (rgn == DSD_RGN_IO) ? gpr_hit(ioa) : 2'h0; // xio would wrap onto ioa
   // bit ops only below io 0x20; displacement-free port form only
   assign bitop = (bit_set | bit_clr | bit_test) && amode == DSD_AM_IOPORT
                  && addr[5:0] < `DSD_IO_BIT_END;
   assign bmask = 8'h01 << bit_idx;

   // current io byte, own registers overlay peripheral data
   always_comb begin
      case (gh)
         2'h1:    cur = r.gpr0;
         2'h2:    cur = r.gpr1;
         2'h3:    cur = r.gpr2;
         default: cur = io_rdata;
      endcase
   end

   //--------------------------------------------------
   // peripheral strobes
   //--------------------------------------------------
   // bad port access: xio via port op is impossible since address is 6 bits
   logic go;
   logic wbit;
   assign go       = req && ce && r.st == DSD_ST_IDLE;
   // bit_set beside bit_test only picks the skip sense, it never writes
   assign wbit     = (bit_set || bit_clr) && !bit_test;
   assign rf_addr  = eff[4:0];
   assign rf_we    = go && we && rgn == DSD_RGN_REG;
   assign io_addr  = eff[7:0];
   assign io_re    = go && (rgn == DSD_RGN_IO || rgn == DSD_RGN_XIO) && (!we || bitop);
   assign io_we    = go && (rgn == DSD_RGN_IO || rgn == DSD_RGN_XIO) && (we || wbit)
                     && gh == 2'h0 && (!wbit || bitop);
   // single-bit ops write one bit; w1c flags elsewhere see zero
   assign io_wmask = wbit ? bmask : 8'hFF;
   assign io_wdata = bit_set ? ((cur & ~io_w1c_mask) | bmask)
                   : bit_clr ? (cur & ~io_w1c_mask & ~bmask)
                   : wdata;
   assign sram_we  = go && we && rgn == DSD_RGN_SRAM;
   assign sram_re  = go && !we && rgn == DSD_RGN_SRAM;

   dsd_sram #(
      .AW(SRAM_AW)
   ) u_sram (
      .mclk  (mclk),
      .ce    (ce),
      .we    (sram_we),
      .re    (sram_re),
      .addr  (SRAM_AW'(eff - `DSD_XIO_END)),
      .wdata (wdata),
      .rdata (sram_rdata)
   );

   //--------------------------------------------------
   // next state
   //--------------------------------------------------
   always_comb begin
      next_r         = r;
      next_r.ack     = 1'b0;
      next_r.skip    = 1'b0;
      next_r.sram_rd = 1'b0;
      if (ee_wr_done) next_r.ee_busy = 1'b0;
      case (r.st)
         DSD_ST_IDLE: begin
            if (ee_rd_strobe) begin
               next_r.st  = DSD_ST_STALL;
               next_r.cnt = `DSD_EE_RD_STALL;
            end else if (ee_wr_strobe) begin
               next_r.st      = DSD_ST_STALL;
               next_r.cnt     = `DSD_EE_WR_STALL;
               next_r.ee_busy = 1'b1;
            end else if (req) begin
               next_r.bad = bitop == 1'b0 && (bit_set | bit_clr | bit_test);
               case (rgn)
                  DSD_RGN_SRAM: begin
                     next_r.st      = DSD_ST_SRAM;
                     next_r.sram_rd = !we;
                  end
                  DSD_RGN_REG: begin
                     next_r.ack   = 1'b1;
                     next_r.rdata = rf_rdata;
                  end
                  DSD_RGN_IO, DSD_RGN_XIO: begin
                     next_r.ack   = 1'b1;
                     next_r.rdata = cur;
                     next_r.skip  = bit_test && bitop && ((cur & bmask) != 8'h00) == bit_set;
                     if (gh != 2'h0 && (we || wbit) && !next_r.bad) begin
                        case (gh)
                           2'h1: next_r.gpr0 = bit_set ? (cur | bmask) : bit_clr ? (cur & ~bmask) : wdata;
                           2'h2: next_r.gpr1 = wdata;
                           default: next_r.gpr2 = wdata;
                        endcase
                     end
                  end
                  default: begin
                     next_r.ack   = 1'b1;
                     next_r.rdata = 8'h00;
                  end
               endcase
            end
         end
         DSD_ST_SRAM: begin
            next_r.st  = DSD_ST_IDLE;
            next_r.ack = 1'b1;
            // array data registered on the taking edge, stable here
            if (r.sram_rd) begin
               next_r.rdata = sram_rdata;
            end
         end
         DSD_ST_STALL: begin
            next_r.cnt = r.cnt - 3'h1;
            if (r.cnt == 3'h1) begin
               next_r.st = DSD_ST_IDLE;
            end
         end
         default: next_r.st = DSD_ST_IDLE;
      endcase
   end

   //--------------------------------------------------
   // registers
   //--------------------------------------------------
   // busy write flag survives reset so the write still finishes
   always_ff @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         r.st      <= DSD_ST_IDLE;
         r.cnt     <= 3'h0;
         r.ack     <= 1'b0;
         r.skip    <= 1'b0;
         r.bad     <= 1'b0;
         r.sram_rd <= 1'b0;
         r.rdata   <= 8'h00;
         r.gpr0    <= 8'h00;
         r.gpr1    <= 8'h00;
         r.gpr2    <= 8'h00;
      end else if (ce) begin
         r.st      <= next_r.st;
         r.cnt     <= next_r.cnt;
         r.ack     <= next_r.ack;
         r.skip    <= next_r.skip;
         r.bad     <= next_r.bad;
         r.sram_rd <= next_r.sram_rd;
         r.rdata   <= next_r.rdata;
         r.gpr0    <= next_r.gpr0;
         r.gpr1    <= next_r.gpr1;
         r.gpr2    <= next_r.gpr2;
         r.ee_busy <= next_r.ee_busy;
      end
   end

   //--------------------------------------------------
   // outputs
   //--------------------------------------------------
   assign ack     = r.ack;
   assign stall   = r.st != DSD_ST_IDLE;
   assign rdata   = r.rdata;
   assign skip    = r.skip;
   assign bad_op  = r.bad;
   assign ee_busy = r.ee_busy;
   assign gpr0    = r.gpr0;
   assign gpr1    = r.gpr1;
   assign gpr2    = r.gpr2;
endmodule
`default_nettype wire

// ---- tb/dsd_periph_model.sv ----
// peripheral-side model: register file and io space behind the decoder
`timescale 1ns/1ps
`default_nettype none
module dsd_periph_model (
   input  wire logic       mclk,
   input  wire logic       arst_n,
   input  wire logic       rf_we,
   input  wire logic [4:0] rf_addr,
   input  wire logic       io_we,
   input  wire logic [7:0] io_addr,
   input  wire logic [7:0] io_wdata,
   input  wire logic [7:0] io_wmask,
   output logic      [7:0] rf_rdata,
   output logic      [7:0] io_rdata,
   output logic      [7:0] io_w1c_mask
);
   // ----------------------------------------
   // storage
   // ----------------------------------------
   localparam logic [7:0] FLAG_ADR = 8'h36;
   logic [7:0] rf [32];
   logic [7:0] io [256];
   logic [7:0] old;
   logic [7:0] hit;
   // same-cycle read data; low nibble at FLAG_ADR is write-one-to-clear
   assign rf_rdata    = rf[rf_addr];
   assign io_rdata    = io[io_addr];
   assign io_w1c_mask = (io_addr == FLAG_ADR) ? 8'h0F : 8'h00;
   assign old         = io[io_addr];
   assign hit         = io_wdata & io_wmask;
   // masked write, flags drop only where a one lands; rf reuses io write data
   always @(posedge mclk or negedge arst_n) begin
      if (!arst_n) begin
         foreach (io[i])
            io[i] <= 8'h00;
         foreach (rf[i])
            rf[i] <= 8'h00;
         io[FLAG_ADR] <= 8'h0F;
      end else begin
         if (rf_we)
            rf[rf_addr] <= io_wdata;
         if (io_we)
            io[io_addr] <= (((old & ~io_wmask) | hit) & ~io_w1c_mask) | (old & io_w1c_mask & ~hit);
      end
   end
endmodule
`default_nettype wire

// ---- tb/dsd_decoder_properties.sv ----
// port assertions for the data space decoder
`timescale 1ns/1ps
`default_nettype none
`include "dsd_params.svh"
module dsd_decoder_properties import dsd_pkg::*; (
   input wire logic        mclk,
   input wire logic        arst_n,
   input wire logic        ce,
   input wire logic        req,
   input wire logic        we,
   input wire dsd_amode_t  amode,
   input wire logic [15:0] addr,
   input wire logic [1:0]  ptr_sel,
   input wire logic [15:0] ptr_val,
   input wire logic        bit_set,
   input wire logic        bit_clr,
   input wire logic        bit_test,
   input wire logic [2:0]  bit_idx,
   input wire logic        ee_rd_strobe,
   input wire logic        ee_wr_strobe,
   input wire logic        rf_we,
   input wire logic [4:0]  rf_addr,
   input wire logic        io_we,
   input wire logic        io_re,
   input wire logic [7:0]  io_addr,
   input wire logic [7:0]  io_wmask,
   input wire logic        ptr_we,
   input wire logic [4:0]  ptr_reg,
   input wire logic [15:0] ptr_next,
   input wire logic        ack,
   input wire logic        stall,
   input wire logic [7:0]  rdata,
   input wire logic        skip,
   input wire logic        bad_op
);
   // ----------------------------------------
   // request decode
   // ----------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!arst_n);
   wire logic tk = ce && req && !stall && !ee_rd_strobe && !ee_wr_strobe;
   wire logic dr = tk && amode == DSD_AM_DIRECT;
   wire logic pt = tk && amode == DSD_AM_IOPORT;
   wire logic bo = bit_set || bit_clr || bit_test;
   // strobe, address, mask, pointer, ack and stall outputs tied to their cause with the exact figure
   reg_write_a: assert property (dr && we && addr < `DSD_REG_END |-> rf_we && rf_addr == addr[4:0] && !io_we)
      else $error("register write misrouted");
   io_alias_a: assert property (pt && !bo |-> io_addr == {2'b00, addr[5:0]} + 8'h20
      && (we ? io_we == !(addr[5:0] inside {`DSD_GPR0_ADR, `DSD_GPR1_ADR, `DSD_GPR2_ADR}) : io_re))
      else $error("port access not aliased");
   xio_read_a: assert property (dr && !we && addr >= `DSD_IO_END && addr < `DSD_XIO_END
      |-> io_re && io_addr == addr[7:0])
      else $error("extended io read misrouted");
   sram_time_a: assert property (dr && addr >= `DSD_XIO_END && addr < `DSD_MAP_TOP |=> stall && !ack ##1 ack)
      else $error("sram access not two cycles");
   unmapped_a: assert property (dr && addr >= `DSD_MAP_TOP
      |-> !rf_we && !io_we ##1 ack && (we || rdata == 8'h00))
      else $error("unmapped access disturbed");
   bit_mask_a: assert property (pt && (bit_set || bit_clr) && !bit_test && addr[5:0] < `DSD_IO_BIT_END
      |-> io_we == (addr[5:0] != `DSD_GPR0_ADR) && io_wmask == 8'h01 << bit_idx)
      else $error("bit op wrote other bits");
   bit_refuse_a: assert property (pt && bo && addr[5:0] >= `DSD_IO_BIT_END |-> !io_we ##1 bad_op)
      else $error("high io bit op accepted");
   ptr_step_a: assert property (tk && (amode == DSD_AM_PREDEC || amode == DSD_AM_POSTINC) |-> ptr_we
      && ptr_next == (amode == DSD_AM_PREDEC ? ptr_val - 16'h0001 : ptr_val + 16'h0001)
      && ptr_reg == (ptr_sel == 2'h0 ? `DSD_PTR_X : ptr_sel == 2'h1 ? `DSD_PTR_Y : `DSD_PTR_Z))
      else $error("pointer update wrong");
   ee_read_a: assert property (ce && ee_rd_strobe && !stall |=> stall [*4] ##1 !stall)
      else $error("eeprom read stall length");
   ee_write_a: assert property (ce && ee_wr_strobe && !stall |=> stall [*2] ##1 !stall)
      else $error("eeprom write stall length");
   // main scenarios reached
   cov_sram_c: cover property (dr && addr >= `DSD_XIO_END && addr < `DSD_MAP_TOP);
   cov_skip_c: cover property (ack && skip);
   cov_ee_c: cover property (ee_rd_strobe && !stall);
endmodule
bind dsd_decoder dsd_decoder_properties u_chk (.*);
`default_nettype wire

// ---- tb/data_space_address_decoder_tb.sv ----
// self-checking bench for the data space decoder
`timescale 1ns/1ps
`default_nettype none
module data_space_address_decoder_tb import dsd_pkg::*;;
   // ----------------------------------------
   // signals and instances
   // ----------------------------------------
   logic        mclk = 0, arst_n = 0, ce = 1, req = 0, we = 0, ee_wr_done = 0;
   logic        bit_set = 0, bit_clr = 0, bit_test = 0, ee_rd_strobe = 0, ee_wr_strobe = 0;
   dsd_amode_t  amode = DSD_AM_DIRECT;
   logic [15:0] addr = 0, ptr_val = 0, ptr_next;
   logic [1:0]  ptr_sel = 0;
   logic [5:0]  disp = 0;
   logic [2:0]  bit_idx = 0;
   logic [7:0]  wdata = 0, rf_rdata, io_rdata, io_w1c_mask, io_addr, io_wdata, io_wmask, rdata, gpr0, gpr1, gpr2;
   logic [4:0]  rf_addr, ptr_reg;
   logic        rf_we, io_we, io_re, ptr_we, ack, stall, skip, bad_op, ee_busy;
   int          err_count = 0, compares = 0, seed = 32'hbc7fb55e, i;
   logic [10:0] q[$];
   logic [10:0] e;
   logic [7:0]  v;
   dsd_decoder dut (.*);
   dsd_periph_model u_mdl (.*);
   always #5 mclk = ~mclk;
   task automatic complete_run;
      if (err_count == 0 && compares > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask
   task automatic fail(input string s);
      err_count++;
      $display("[ERR] %0t %s", $time, s);
   endtask
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      compares++;
      if (got !== exp) fail("value mismatch");
   endtask
   // each ack retires the oldest note: {care skip, care data, skip, data}
   always @(negedge mclk) begin
      if (ack === 1'b1) begin
         e = q.size() ? q.pop_front() : 11'h7FF;
         compares++;
         if (e[10] && skip !== e[8]) fail("skip mismatch");
         if (e[9] && rdata !== e[7:0]) fail("read data mismatch");
      end
   end
   // one request, dropped after the taking edge, then a bounded wait for ack
   task automatic op(input dsd_amode_t m, input logic [15:0] a, input logic w, input logic [7:0] d,
                     input logic [2:0] b, input logic [10:0] x);
      int k;
      @(negedge mclk);
      amode = m;
      {addr, we, wdata, bit_idx, bit_set, bit_clr, bit_test, req} = {a, w, d, d[2:0], b, 1'b1};
      q.push_back(x);
      @(negedge mclk);
      req = 1'b0;
      for (k = 0; k < 8 && ack !== 1'b1; k++) @(negedge mclk);
      if (k == 8) begin
         fail("no ack");
         complete_run;
      end
   endtask
   // eeprom strobe, then count stall cycles under a bound
   task automatic ee(input logic wr, input int x);
      int k;
      @(negedge mclk);
      {ee_wr_strobe, ee_rd_strobe} = {wr, !wr};
      @(negedge mclk);
      {ee_wr_strobe, ee_rd_strobe} = 2'b00;
      for (k = 0; k < 9 && stall === 1'b1; k++) @(negedge mclk);
      compares++;
      if (k != x) fail("stall length");
   endtask
   // ----------------------------------------
   // main sequence
   // ----------------------------------------
   initial begin
      repeat (6) @(negedge mclk);
      arst_n = 1'b1;
      v = 8'($random(seed));
      op(DSD_AM_IOPORT, 16'h0005, 1'b1, v, 3'h0, 11'h000);
      op(DSD_AM_DIRECT, 16'h0025, 1'b0, 8'h00, 3'h0, {3'b010, v});
      op(DSD_AM_DIRECT, 16'h001F, 1'b1, ~v, 3'h0, 11'h000);
      op(DSD_AM_DIRECT, 16'h001F, 1'b0, 8'h00, 3'h0, {3'b010, ~v});
      op(DSD_AM_DIRECT, 16'h00FF, 1'b1, v + 8'h01, 3'h0, 11'h000);
      op(DSD_AM_DIRECT, 16'h00FF, 1'b0, 8'h00, 3'h0, {3'b010, v + 8'h01});
      op(DSD_AM_DIRECT, 16'h0100, 1'b1, v, 3'h0, 11'h000);
      op(DSD_AM_DIRECT, 16'h10FF, 1'b1, ~v, 3'h0, 11'h000);
      op(DSD_AM_DIRECT, 16'h0100, 1'b0, 8'h00, 3'h0, {3'b010, v});
      op(DSD_AM_DIRECT, 16'h10FF, 1'b0, 8'h00, 3'h0, {3'b010, ~v});
      op(DSD_AM_DIRECT, 16'h1100, 1'b1, v, 3'h0, 11'h000);
      op(DSD_AM_DIRECT, 16'h1100, 1'b0, 8'h00, 3'h0, 11'h200);
      op(DSD_AM_IOPORT, 16'h0016, 1'b0, 8'h07, 3'b100, 11'h000);
      op(DSD_AM_DIRECT, 16'h0036, 1'b0, 8'h00, 3'h0, 11'h28F);
      op(DSD_AM_IOPORT, 16'h0016, 1'b1, 8'h01, 3'h0, 11'h000);
      ptr_val = 16'h0020;
      disp = 6'h16;
      op(DSD_AM_DISP, 16'h0000, 1'b0, 8'h00, 3'h0, 11'h20E);
      op(DSD_AM_IOPORT, 16'h0016, 1'b0, 8'h03, 3'b101, 11'h500);
      op(DSD_AM_IOPORT, 16'h0016, 1'b0, 8'h03, 3'b001, 11'h400);
      op(DSD_AM_IOPORT, 16'h0016, 1'b0, 8'h07, 3'b001, 11'h500);
      op(DSD_AM_DISP, 16'h0000, 1'b0, 8'h00, 3'h0, 11'h20E);
      op(DSD_AM_IOPORT, 16'h002A, 1'b0, 8'h01, 3'b100, 11'h000);
      chk({7'h00, bad_op}, 8'h01);
      op(DSD_AM_IOPORT, 16'h001E, 1'b1, v, 3'h0, 11'h000);
      op(DSD_AM_IOPORT, 16'h001E, 1'b0, 8'h00, 3'b010, 11'h000);
      chk(gpr0, v & 8'hFE);
      op(DSD_AM_IOPORT, 16'h002A, 1'b1, ~v, 3'h0, 11'h000);
      op(DSD_AM_IOPORT, 16'h002B, 1'b1, v, 3'h0, 11'h000);
      op(DSD_AM_DIRECT, 16'h004A, 1'b0, 8'h00, 3'h0, {3'b010, ~v});
      chk(gpr1, ~v);
      chk(gpr2, v);
      for (i = 0; i < 3; i++) begin
         ptr_sel = 2'(i);
         ptr_val = {11'h000, 5'($random(seed)) | 5'h01};
         op(DSD_AM_PREDEC, 16'h0000, 1'b0, 8'h00, 3'h0, 11'h000);
         op(DSD_AM_POSTINC, 16'h0000, 1'b0, 8'h00, 3'h0, 11'h000);
      end
      ee(1'b0, 4);
      ee(1'b1, 2);
      // a strobe while the enable is low must leave the state frozen
      @(negedge mclk);
      {ce, ee_rd_strobe} = 2'b01;
      repeat (3) @(negedge mclk);
      compares++;
      if (stall !== 1'b0) fail("state moved while frozen");
      {ce, ee_rd_strobe} = 2'b10;
      @(negedge mclk);
      arst_n = 1'b0;
      repeat (2) @(negedge mclk);
      arst_n = 1'b1;
      chk({7'h00, ee_busy}, 8'h01);
      ee_wr_done = 1'b1;
      @(negedge mclk);
      ee_wr_done = 1'b0;
      @(negedge mclk);
      chk({7'h00, ee_busy}, 8'h00);
      compares++;
      if (q.size() != 0) fail("answer missing");
      complete_run;
   end
endmodule
`default_nettype wire
